// [scdm_clock_ctrl.v]
/*
  System clock divider/multiplier. Produces one-cycle tick strobes for
  the system clock, machine cycle, timers 0/1, timer 2 and baud
  generator, serial mode 0 and serial mode 2, plus an Avalon-MM register
  slave for the control and flag bits.
  Assumes clk_i runs at four times the oscillator rate so that every
  selectable rate is a whole number of clk_i cycles; the alt clock mode
  status arrives asynchronously from a pin.
*/
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "scdm_consts.vh"

module scdm_clock_ctrl
#(
  parameter LOCK_CLK = `SCDM_LOCK_OSC * `SCDM_CLK_PER_OSC  // multiplier lock wait
)
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // avalon-mm register slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // asynchronous status pin
  input  wire        alt_clock_mode_status_i,
  // rate strobes and divide select in force
  output wire        sys_tick_o,
  output wire        mc_tick_o,
  output wire        timer01_tick_o,
  output wire        timer2_tick_o,
  output wire        ser0_tick_o,
  output wire        ser2_tick_o,
  output wire [1:0]  active_cd_o
);

  // multiplier entry sequence states
  localparam SEQ_IDLE    = 2'h0;  // nothing done yet
  localparam SEQ_CLEARED = 2'h1;  // enable cleared in divide-by-4
  localparam SEQ_FACTOR  = 2'h2;  // factor written with enable clear
  localparam SEQ_ARMED   = 2'h3;  // enable set, lock wait running

  localparam NTICK = 6;           // number of strobe counters
  localparam CW    = 17;          // counter width, holds 65536

  // period in clk_i cycles of one oscillator count; the product is
  // wider than a counter, so it is cut to CW bits on purpose
  function [CW-1:0] osc2clk;
    input [31:0] osc;
    reg   [31:0] prod;
    begin
      prod    = osc * `SCDM_CLK_PER_OSC;
      osc2clk = prod[CW-1:0];
    end
  endfunction

  // counter period scaled by a whole factor, cut to CW bits on purpose;
  // every product used here stays below 2^CW
  function [CW-1:0] scale;
    input [CW-1:0] per_in;
    input [31:0]   fac;
    reg   [31:0]   prod;
    begin
      prod  = per_in * fac;
      scale = prod[CW-1:0];
    end
  endfunction

  // system clock period in clk_i cycles for a divide setting
  function [CW-1:0] sys_per;
    input [1:0] cd;
    input       fx;
    begin
      case (cd)
        `SCDM_CD_MUL:     sys_per = fx ? 17'h1 : 17'h2;  // x4 / x2
        `SCDM_CD_LOWRATE: sys_per = osc2clk(`SCDM_SLOW_DIV);
        default:          sys_per = osc2clk(32'h1);      // raw oscillator
      endcase
    end
  endfunction

  // register file
  reg  [1:0]  cd_ff;              // accepted divide select
  reg  [1:0]  active_cd_ff;       // divide select in force
  reg         factor_ff;          // multiply_factor_select
  reg         active_fx_ff;       // factor in force
  reg         mul_en_ff;          // multiplier_enable
  reg         ready_ff;           // multiplier_ready_flag
  reg  [3:0]  rate_sel_ff;        // timer/serial rate selects
  reg  [1:0]  seq_ff;             // entry sequence progress
  reg         pend_ff;            // rate change waiting for mc edge
  reg  [18:0] lock_cnt_ff;        // lock wait counter
  reg         alt_meta_ff;        // synchroniser stage 1
  reg         alt_sync_ff;        // synchroniser stage 2
  // bus
  reg         ack_ff;             // answer cycle of a request
  reg  [31:0] rdata_ff;           // registered read data
  // strobes
  reg  [CW-1:0]    cnt_ff [0:NTICK-1];
  reg  [NTICK-1:0] tick_ff;

  wire        req      = avs_read_i | avs_write_i;
  wire        wr_go    = avs_write_i & ack_ff & avs_byteenable_i[0];
  wire [7:0]  wbyte    = avs_writedata_i[7:0];
  wire        wr_pwr   = wr_go & (avs_address_i == `SCDM_OFS_PWR);
  wire        wr_rate  = wr_go & (avs_address_i == `SCDM_OFS_RATE);
  wire [1:0]  new_cd   = {wbyte[`SCDM_CD_HI], wbyte[`SCDM_CD_LO]};
  wire        new_en   = wbyte[`SCDM_MUL_EN];
  wire        new_fx   = wbyte[`SCDM_FACTOR];
  wire        in_div4  = (cd_ff == `SCDM_CD_DIV4);
  wire        lowrate  = (active_cd_ff == `SCDM_CD_LOWRATE);

  assign avs_waitrequest_o = req & ~ack_ff;  // one wait cycle per access
  assign avs_readdata_o    = rdata_ff;

  // divide-select acceptance check
  reg         cd_ok;
  always @*
  begin
    cd_ok = 1'b0;
    if (new_cd == `SCDM_CD_RSVD)
      cd_ok = 1'b0;                                        // RULE16
    else if (new_cd == cd_ff)
      cd_ok = 1'b1;                                        // no change
    else if (new_cd == `SCDM_CD_MUL)
      cd_ok = in_div4 & (seq_ff == SEQ_ARMED) & ready_ff
              & mul_en_ff & new_en;                        // RULE8
    else if (in_div4 | (new_cd == `SCDM_CD_DIV4))
      cd_ok = 1'b1;                                        // RULE6 RULE11
    else
      cd_ok = 1'b0;                                        // RULE6
  end

  // sequence tracker next state
  reg  [1:0]  nxt_seq;
  always @*
  begin
    nxt_seq = seq_ff;
    if (wr_pwr)
    begin
      if (!in_div4 || alt_sync_ff)
        nxt_seq = SEQ_IDLE;                    // only from 10 with alt mode 0
      else
        case (seq_ff)
          SEQ_IDLE:    nxt_seq = new_en ? SEQ_IDLE : SEQ_CLEARED;
          SEQ_CLEARED: nxt_seq = new_en ? SEQ_IDLE : SEQ_FACTOR;
          SEQ_FACTOR:  nxt_seq = new_en ? SEQ_ARMED : SEQ_FACTOR;
          SEQ_ARMED:   nxt_seq = new_en ? SEQ_ARMED : SEQ_CLEARED;
          default:     nxt_seq = SEQ_IDLE;
        endcase
    end
  end

  // bus slave: request held until waitrequest drops
  // ack_ff is high only in the answer cycle, so a held request is seen
  // once and its write lands at exactly one edge
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (avs_read_i & ~ack_ff)
        case (avs_address_i)
          `SCDM_OFS_PWR:
            rdata_ff <= {24'h0, cd_ff, 1'b0, mul_en_ff, factor_ff, 3'h0};
          `SCDM_OFS_FLAG:
            rdata_ff <= {24'h0, active_cd_ff, 2'h0, ready_ff, alt_sync_ff, 2'h0};
          `SCDM_OFS_RATE:
            rdata_ff <= {28'h0, rate_sel_ff};
          default:
            rdata_ff <= 32'h0;                 // unmapped reads as zero
        endcase
    end
  end

  // pin synchroniser, stage 1 feeds only stage 2
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      alt_meta_ff <= 1'b0;
      alt_sync_ff <= 1'b0;
    end
    else
    begin
      alt_meta_ff <= alt_clock_mode_status_i;
      alt_sync_ff <= alt_meta_ff;
    end
  end

  // control register writes and sequence tracking
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cd_ff       <= `SCDM_CD_RESET;
      factor_ff   <= 1'b0;
      mul_en_ff   <= 1'b0;
      rate_sel_ff <= 4'h0;
      seq_ff      <= SEQ_IDLE;
    end
    else
    begin
      seq_ff <= nxt_seq;
      if (wr_pwr)
      begin
        if (cd_ok)
          cd_ff <= new_cd;                                 // RULE6 RULE8
        // enable may not drop while the multiplier drives the clock
        if (cd_ff != `SCDM_CD_MUL)
        begin
          mul_en_ff <= new_en;
          if (!mul_en_ff)
            factor_ff <= new_fx;               // factor frozen while enabled
        end
      end
      if (wr_rate)
        rate_sel_ff <= wbyte[3:0];
    end
  end

  // multiplier lock wait and ready flag
  // the counter stops once the flag is up, so it never wraps
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lock_cnt_ff <= 19'h0;
      ready_ff    <= 1'b0;
    end
    else if (!mul_en_ff)
    begin
      lock_cnt_ff <= 19'h0;                    // lock lost with enable
      ready_ff    <= 1'b0;
    end
    else if (lock_cnt_ff >= LOCK_CLK[18:0] - 19'h1)
      ready_ff <= 1'b1;                                    // RULE9
    else
      lock_cnt_ff <= lock_cnt_ff + 19'h1;
  end

  // apply the accepted setting at the next machine-cycle edge
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      active_cd_ff <= `SCDM_CD_RESET;
      active_fx_ff <= 1'b0;
      pend_ff      <= 1'b0;
    end
    else if (pend_ff & tick_ff[1])
    begin
      active_cd_ff <= cd_ff;                               // RULE5 RULE10
      active_fx_ff <= factor_ff;                           // RULE3
      pend_ff      <= 1'b0;
    end
    // a change written back before it applied is dropped here, so the
    // strobes are not restarted for nothing
    else
      pend_ff <= (cd_ff != active_cd_ff);
  end

  // strobe periods in clk_i cycles
  reg  [CW-1:0] per [0:NTICK-1];
  reg  [CW-1:0] mc_per;
  always @*
  begin
    per[0] = sys_per(active_cd_ff, active_fx_ff);          // RULE1 RULE3
    mc_per = scale(per[0], `SCDM_MC_SYS);                  // RULE2 RULE4
    per[1] = mc_per;
    // timers 0 and 1
    if (rate_sel_ff[`SCDM_TIMER_DIV])
      per[2] = mc_per;                                     // RULE12
    else
      per[2] = lowrate ? osc2clk(`SCDM_T01_LOWRATE)
                       : osc2clk(`SCDM_T01_FIXED);         // RULE12
    // timer 2 and baud generator ignore their divide select
    per[3] = lowrate ? osc2clk(`SCDM_T2_LOWRATE)
                     : osc2clk(`SCDM_T2_FAST);             // RULE13
    // serial mode 0
    if (rate_sel_ff[`SCDM_SER0_RATE])
      per[4] = mc_per;                                     // RULE14
    else
      per[4] = scale(mc_per, `SCDM_SER0_MULT);             // RULE14
    // serial mode 2; low-rate slow count needs the full counter width
    if (lowrate)
      per[5] = rate_sel_ff[`SCDM_SER_DOUBLE] ? osc2clk(`SCDM_SER2_LR_FAST)  // RULE15
                                            : osc2clk(`SCDM_SER2_LR_SLOW);
    else
      per[5] = rate_sel_ff[`SCDM_SER_DOUBLE] ? osc2clk(`SCDM_SER2_FAST)  // RULE15
                                            : osc2clk(`SCDM_SER2_SLOW);
  end

  // strobe counters; all restart together when a new rate is applied
  integer i;
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tick_ff <= {NTICK{1'b0}};
      for (i = 0; i < NTICK; i = i + 1)
        cnt_ff[i] <= {CW{1'b0}};
    end
    else
    begin
      for (i = 0; i < NTICK; i = i + 1)
      begin
        if (pend_ff & tick_ff[1])
        begin
          cnt_ff[i]  <= {CW{1'b0}};            // glitch-free restart
          tick_ff[i] <= 1'b0;
        end
        else if (cnt_ff[i] >= per[i] - 17'h1)
        begin
          cnt_ff[i]  <= {CW{1'b0}};
          tick_ff[i] <= 1'b1;                              // RULE15
        end
        else
        begin
          cnt_ff[i]  <= cnt_ff[i] + 17'h1;
          tick_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign sys_tick_o     = tick_ff[0];
  assign mc_tick_o      = tick_ff[1];
  assign timer01_tick_o = tick_ff[2];
  assign timer2_tick_o  = tick_ff[3];
  assign ser0_tick_o    = tick_ff[4];
  assign ser2_tick_o    = tick_ff[5];
  assign active_cd_o    = active_cd_ff;

endmodule

// [scdm_clock_ctrl_chk.sv]
/*
  checker for scdm_clock_ctrl: bus wait, divide-select moves, tick gaps.
  assumes it is bound to the top module, every pin by name.
*/
`timescale 1ns/1ps

module scdm_clock_ctrl_chk
(
  // clock and reset
  input wire        clk_i,
  input wire        rstn_i,
  // register bus
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  // strobes and mode
  input wire        sys_tick_o,
  input wire        mc_tick_o,
  input wire        timer2_tick_o,
  input wire [1:0]  active_cd_o
);
  reg  [12:0] cnt_ff [0:2];  // cycles since last tick
  reg  [2:0]  seen_ff;       // tick seen since last switch
  reg  [1:0]  cd_ff;         // mode one cycle ago
  integer     i;
  wire [2:0]  tk = {timer2_tick_o, mc_tick_o, sys_tick_o};
  wire        lr = (active_cd_o == 2'h3);
  // multiplier gaps hang on a hidden factor, so only 10 and 11 are judged
  wire        ok = (cd_ff == active_cd_o) && active_cd_o[1];
  // a switch restarts the counters, so the first gap after it is skipped
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      seen_ff <= 3'h0;
      cd_ff   <= 2'h2;
      for (i = 0; i < 3; i = i + 1)
        cnt_ff[i] <= 13'h0;
    end
    else
    begin
      cd_ff <= active_cd_o;
      for (i = 0; i < 3; i = i + 1)
      begin
        cnt_ff[i]  <= tk[i] ? 13'h1 : cnt_ff[i] + 13'h1;
        seen_ff[i] <= (cd_ff == active_cd_o) && (seen_ff[i] || tk[i]);
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wait;
    $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait not one cycle");
  property p_rdz; avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("upper read bits set");
  property p_rsvd; active_cd_o != 2'h1; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode in force");
  property p_pass; $changed(active_cd_o) |-> (active_cd_o == 2'h2) || ($past(active_cd_o) == 2'h2); endproperty
  a_pass: assert property (p_pass) else $error("mode move skips 10");
  property p_gap; $changed(active_cd_o) |-> !mc_tick_o; endproperty
  a_gap: assert property (p_gap) else $error("tick on switch cycle");
  property p_sys; sys_tick_o && seen_ff[0] && ok |-> cnt_ff[0] == (lr ? 13'h400 : 13'h4); endproperty
  a_sys: assert property (p_sys) else $error("system tick gap");
  property p_mc; mc_tick_o && seen_ff[1] && ok |-> cnt_ff[1] == (lr ? 13'h1000 : 13'h10); endproperty
  a_mc: assert property (p_mc) else $error("machine tick gap");
  property p_t2; timer2_tick_o && seen_ff[2] && ok |-> cnt_ff[2] == (lr ? 13'h800 : 13'h8); endproperty
  a_t2: assert property (p_t2) else $error("timer two tick gap");
  property p_one; mc_tick_o |=> !mc_tick_o; endproperty
  a_one: assert property (p_one) else $error("machine tick too long");
  c_lr: cover property (active_cd_o == 2'h3);
  c_mul: cover property (active_cd_o == 2'h0);
  c_rd: cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind scdm_clock_ctrl scdm_clock_ctrl_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .sys_tick_o(sys_tick_o), .mc_tick_o(mc_tick_o),
  .timer2_tick_o(timer2_tick_o), .active_cd_o(active_cd_o));

// [scdm_consts.vh]
/*
  Constants for the system clock divider/multiplier block: register
  offsets, field positions, reset values, mode codes and timing counts.
  Assumes it is included by bare name from the design file.
*/
// Contract
// RULE1 - three-way source select from divide field
// RULE2 - machine cycle is system clock divided by four
// RULE3 - divide field zero enables multiplier, factor two/four
// RULE4 - oscillator clocks per machine cycle per encoding
// RULE5 - new rate applies one machine cycle later
// RULE6 - field changes must pass through 10
// RULE7 - software checks 10 and alt mode before multiplier
// RULE8 - clear enable, factor, enable, ready, write 00
// RULE9 - ready flag set about 65536 oscillator cycles later
// RULE10 - multiplier engages machine cycle after 00 write
// RULE11 - leaving multiplier needs only a field change
// RULE12 - timers 0/1 rate follows timer divide select
// RULE13 - timer 2 every 2, or 512 low-rate
// RULE14 - serial mode 0 at one or three machine cycles
// RULE15 - serial mode 2 at 64/32, low-rate 16384/8192
// RULE16 - reserved 01 encoding is rejected
`ifndef SCDM_CONSTS_VH
`define SCDM_CONSTS_VH

// register byte offsets
`define SCDM_OFS_PWR       4'h0
`define SCDM_OFS_FLAG      4'h4
`define SCDM_OFS_RATE      4'h8

// power_mgmt_reg fields
`define SCDM_CD_HI         7
`define SCDM_CD_LO         6
`define SCDM_MUL_EN        4
`define SCDM_FACTOR        3
// external_flag_register fields
`define SCDM_READY         3
`define SCDM_ALT_MODE      2
// rate select register fields
`define SCDM_TIMER_DIV     0
`define SCDM_TIMER2_DIV    1
`define SCDM_SER0_RATE     2
`define SCDM_SER_DOUBLE    3

// divide select encodings
`define SCDM_CD_MUL        2'h0
`define SCDM_CD_RSVD       2'h1
`define SCDM_CD_DIV4       2'h2
`define SCDM_CD_LOWRATE    2'h3
`define SCDM_CD_RESET      2'h2

// clk_i cycles per oscillator cycle (lets the 4x sysclk be one clk_i)
`define SCDM_CLK_PER_OSC   4
// oscillator cycle counts, except SCDM_MC_SYS and SCDM_SER0_MULT, which are multipliers
`define SCDM_LOCK_OSC      65536
`define SCDM_SLOW_DIV      256
`define SCDM_MC_SYS        4
`define SCDM_T01_FIXED     12
`define SCDM_T01_LOWRATE   3072
`define SCDM_T2_FAST       2
`define SCDM_T2_LOWRATE    512
`define SCDM_SER0_MULT     3
`define SCDM_SER2_SLOW     64
`define SCDM_SER2_FAST     32
`define SCDM_SER2_LR_SLOW  16384
`define SCDM_SER2_LR_FAST  8192

`endif

// [tb_scdm_clock_ctrl.sv]
/*
  bench for scdm_clock_ctrl: registers, strobe gaps, mode moves, lock.
  assumes a short lock count of 64 clk_i cycles.
*/
`timescale 1ns/1ps

module tb_scdm_clock_ctrl;
  reg         clk_i = 1'b0;
  reg         rstn_i = 1'b0;
  reg  [3:0]  avs_address_i = 4'h0;
  reg         avs_read_i = 1'b0;
  reg         avs_write_i = 1'b0;
  reg  [31:0] avs_writedata_i = 32'h0;
  reg  [3:0]  avs_byteenable_i = 4'h0;
  reg         alt_i = 1'b0;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o;
  wire [5:0]  tk;              // ser2 ser0 t2 t01 mc sys
  wire [1:0]  active_cd_o;
  reg  [31:0] rd;
  reg  [27:0] rows [0:10];     // addr, write, enables, data, expected
  integer     fail_count = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     k;

  always #2.5 clk_i = ~clk_i;

  scdm_clock_ctrl #(.LOCK_CLK(64)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .alt_clock_mode_status_i(alt_i), .sys_tick_o(tk[0]), .mc_tick_o(tk[1]),
    .timer01_tick_o(tk[2]), .timer2_tick_o(tk[3]), .ser0_tick_o(tk[4]),
    .ser2_tick_o(tk[5]), .active_cd_o(active_cd_o));

  task results;
  begin
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task cmp(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // one bus cycle; request held until waitrequest is sampled low at a
  // rising edge, where read data is taken and the request released
  task av(input [3:0] a, input w, input [3:0] b, input [7:0] d);
  begin
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_byteenable_i <= b;
    avs_writedata_i <= {24'h0, d};
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  end
  endtask

  task pw(input [7:0] d);
    av(4'h0, 1'b1, 4'h1, d);
  endtask

  task rq(input [3:0] a);
    av(a, 1'b0, 4'h1, 8'h0);
  endtask

  // gap between two ticks of one strobe, in clk_i cycles
  task pk(input integer s, input integer e);
  begin
    k = 0;
    @(negedge clk_i);
    while (tk[s] !== 1'b1)
      @(negedge clk_i);
    do
    begin
      @(negedge clk_i);
      k = k + 1;
    end while (tk[s] !== 1'b1);
    cmp(k, e);
  end
  endtask

  // low rate may take a whole slow machine cycle to switch
  task wcd(input [1:0] c);
  begin
    k = 0;
    while (active_cd_o !== c && k < 5000)
    begin
      @(negedge clk_i);
      k = k + 1;
    end
    cmp(active_cd_o, c);
  end
  endtask

  // hang guard, well above the longest path of about 39000 cycles
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end

  initial
  begin
    rows = '{28'h0010080, 28'h4010080, 28'h8010000, 28'h8110f00, 28'h801000f,
             28'hc11ff00, 28'hc010000, 28'h8100000, 28'h801000f, 28'h0114000,
             28'h0010080};
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (k = 0; k < 11; k = k + 1)
    begin
      av(rows[k][27:24], rows[k][20], rows[k][19:16], rows[k][15:8]);
      if (!rows[k][20])
        cmp(rd, {24'h0, rows[k][7:0]});
    end
    pk(1, 16);
    pk(0, 4);
    pk(3, 8);
    pk(2, 16);
    pk(4, 16);
    pk(5, 128);
    av(4'h8, 1'b1, 4'h1, 8'h00);
    pk(2, 48);
    pk(4, 48);
    pk(5, 256);
    pw(8'hc0);
    wcd(2'h3);
    cmp(k > 0 && k < 19, 1'b1);
    pk(1, 4096);
    pk(3, 2048);
    pk(2, 12288);
    pw(8'h00);
    rq(4'h0);
    cmp(rd[7:6], 2'h3);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp(active_cd_o, 2'h2);
    rstn_i <= 1'b1;
    // alt mode up: the whole sequence must be refused
    alt_i <= 1'b1;
    pw(8'h80);
    pw(8'h88);
    pw(8'h98);
    repeat (100) @(posedge clk_i);
    pw(8'h18);
    rq(4'h0);
    cmp(rd[7:6], 2'h2);
    rq(4'h4);
    cmp(rd[2], 1'b1);
    alt_i <= 1'b0;
    // enable before the factor step: refused
    pw(8'h80);
    pw(8'h90);
    repeat (100) @(posedge clk_i);
    pw(8'h10);
    rq(4'h0);
    cmp(rd[7:6], 2'h2);
    pw(8'h80);
    pw(8'h88);
    pw(8'h98);
    rq(4'h4);
    cmp(rd[3], 1'b0);
    repeat (70) @(posedge clk_i);
    rq(4'h4);
    cmp(rd[3], 1'b1);
    pw(8'h18);
    wcd(2'h0);
    cmp(k > 0 && k < 19, 1'b1);
    pk(1, 4);
    pk(0, 1);
    pk(3, 8);
    pw(8'h98);
    wcd(2'h2);
    cmp(k > 0 && k < 19, 1'b1);
    // second entry, factor two this time
    pw(8'h80);
    pw(8'h80);
    pw(8'h90);
    repeat (70) @(posedge clk_i);
    pw(8'h10);
    wcd(2'h0);
    pk(1, 8);
    pk(0, 2);
    results;
  end
endmodule
